// File: fis_pkg.sv
// package: constants, types and operation list for the flash sequencer
package fis_pkg;
  localparam int FIS_AW = 14;
  localparam int FIS_PAGE_BYTES = 512;
  localparam int FIS_FLASH_BYTES = 16384;
  // register word offsets on wishbone
  localparam logic [3:0] FIS_OFS_DATA = 4'h0;
  localparam logic [3:0] FIS_OFS_ADRH = 4'h1;
  localparam logic [3:0] FIS_OFS_ADRL = 4'h2;
  localparam logic [3:0] FIS_OFS_MODE = 4'h3;
  localparam logic [3:0] FIS_OFS_KEY = 4'h4;
  localparam logic [3:0] FIS_OFS_CTRL = 4'h5;
  localparam logic [3:0] FIS_OFS_CLK = 4'h6;
  localparam logic [3:0] FIS_OFS_BOOT = 4'h7;
  localparam logic [3:0] FIS_OFS_LIMIT = 4'h8;
  // control bit positions
  localparam int FIS_CTRL_EN = 7;
  localparam int FIS_CTRL_BS = 6;
  localparam int FIS_CTRL_RST = 5;
  localparam int FIS_CTRL_FAIL = 4;
  // mode codes
  localparam logic [2:0] FIS_MS_STBY = 3'h0;
  localparam logic [2:0] FIS_MS_READ = 3'h1;
  localparam logic [2:0] FIS_MS_PROG = 3'h2;
  localparam logic [2:0] FIS_MS_ERASE = 3'h3;
  localparam logic [7:0] FIS_KEY1 = 8'h46;
  localparam logic [7:0] FIS_KEY2 = 8'hB9;
  // reset values and loader base
  localparam logic [7:0] FIS_RST_DATA = 8'hFF;
  localparam logic [7:0] FIS_RST_ZERO = 8'h00;
  localparam logic [13:0] FIS_RST_LIMIT = 14'h39FF;
  localparam logic [13:0] FIS_LDR_BASE = 14'h3A00;
  // flash timing, time base ticks per operation
  localparam int FIS_T_READ = 2;
  localparam int FIS_T_PROG = 20;
  localparam int FIS_T_ERASE = 200;
  typedef struct packed {
    logic [2:0] mode;
    logic [13:0] addr;
    logic [7:0] wdata;
  } fis_cmd_t;
endpackage

// File: fis_flash_array.sv
// flash storage array with program-to-zero and page erase
`timescale 1ns/10ps
module fis_flash_array
  import fis_pkg::*;
(
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic erase_i,
  input wire logic [13:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [13:0] fetch_addr_i,
  output logic [7:0] rdata_o,
  output logic [7:0] fetch_data_o
);
  logic [7:0] mem [FIS_FLASH_BYTES];
  logic [4:0] page;
  assign page = addr_i[13:9];
  // erase walks only the addressed page, so idle cycles cost nothing
  // no reset on the array, like real flash
  always_ff @(posedge clk_i) begin
    if (erase_i) begin
      for (int i = 0; i < FIS_PAGE_BYTES; i++) begin
        mem[{page, 9'(i)}] <= 8'hFF;
      end
    end
    if (we_i) begin
      mem[addr_i] <= mem[addr_i] & wdata_i;
    end
    rdata_o <= mem[addr_i];
    fetch_data_o <= mem[fetch_addr_i];
  end
endmodule

// File: fis_sequencer.sv
// flash self-programming sequencer with wishbone registers and boot logic
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/10ps
module fis_sequencer
  import fis_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic hw_boot_loader_option_i,
  input wire logic loader_mem_option_i,
  input wire logic hw_boot_on_ext_reset_i,
  input wire logic ext_reset_done_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [13:0] cpu_fetch_addr_i,
  output logic [7:0] cpu_fetch_data_o,
  input wire logic [7:0] irq_req_i,
  output logic [7:0] irq_pend_o,
  output logic cpu_freeze_o,
  output logic sw_reset_o,
  output logic boot_loader_o,
  output logic [13:0] boot_pc_o
);
  typedef enum {ST_IDLE, ST_RUN, ST_DONE} fis_state_t;
  fis_state_t state_reg, state_next;

  logic [7:0] flash_data_port_reg, flash_addr_high_reg, flash_addr_low_reg;
  logic [2:0] flash_mode_select_reg;
  logic prog_engine_enable_reg, sw_boot_target_reg, command_fail_flag_reg;
  logic [5:0] flash_timebase_div_reg;
  logic [13:0] limit_reg;
  logic key_armed_reg, boot_loader_reg, sw_reset_reg, ack_reg;
  logic [7:0] irq_pend_reg;
  logic [5:0] tb_cnt_reg;
  logic [7:0] op_cnt_reg;
  fis_cmd_t cmd_reg;
  logic [7:0] flash_rdata;

  // bus decode; input from the cpu side is same clock domain
  // a request counts once; ack or err ends it for one cycle
  wire logic bus_req = wb_cyc_i & wb_stb_i & ~ack_reg & ~wb_err_o;
  wire logic [3:0] reg_idx = wb_adr_i[5:2];
  wire logic mapped = (reg_idx <= FIS_OFS_LIMIT);
  wire logic wr = bus_req & wb_we_i & wb_sel_i[0] & mapped;
  wire logic [7:0] wd = wb_dat_i[7:0];
  wire logic [13:0] tgt_addr = {flash_addr_high_reg[5:0], flash_addr_low_reg};
  wire logic mode_ok = (flash_mode_select_reg == FIS_MS_READ) |
    (flash_mode_select_reg == FIS_MS_PROG) |
    (flash_mode_select_reg == FIS_MS_ERASE);
  wire logic addr_ok = (tgt_addr <= limit_reg);
  wire logic key_wr = wr & (reg_idx == FIS_OFS_KEY);
  wire logic trigger = key_wr & key_armed_reg & (wd == FIS_KEY2) &
    prog_engine_enable_reg & (state_reg == ST_IDLE);
  wire logic launch = trigger & mode_ok & addr_ok;
  wire logic tick = (tb_cnt_reg == 6'h0);
  wire logic [7:0] op_len = (cmd_reg.mode == FIS_MS_ERASE) ?
    8'(FIS_T_ERASE) : (cmd_reg.mode == FIS_MS_PROG) ? 8'(FIS_T_PROG) :
    8'(FIS_T_READ);
  wire logic op_end = (state_reg == ST_RUN) & tick & (op_cnt_reg == op_len);
  wire logic ctrl_wr = wr & (reg_idx == FIS_OFS_CTRL);
  // 101 and 111 both request reboot
  wire logic sw_reset_trigger_req = ctrl_wr & wd[FIS_CTRL_EN] & wd[FIS_CTRL_RST];

  // state machine for operation flow
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (launch) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (op_end) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_armed_reg <= 1'b0;
    end else if (key_wr) begin
      key_armed_reg <= (wd == FIS_KEY1);
    end
  end

  // time base prescaler and operation counter
  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg != ST_RUN) begin
      tb_cnt_reg <= flash_timebase_div_reg;
      op_cnt_reg <= 8'h00;
    end else if (tick) begin
      tb_cnt_reg <= flash_timebase_div_reg;
      op_cnt_reg <= op_cnt_reg + 8'h01;
    end else begin
      tb_cnt_reg <= tb_cnt_reg - 6'h01;
    end
  end

  // latch the command at launch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_reg <= '0;
    end else if (launch) begin
      cmd_reg <= '{mode: flash_mode_select_reg, addr: tgt_addr,
                   wdata: flash_data_port_reg};
    end
  end

  // program and erase act on the array at the end
  wire logic do_prog = op_end & (cmd_reg.mode == FIS_MS_PROG);
  wire logic do_erase = op_end & (cmd_reg.mode == FIS_MS_ERASE);
  wire logic [13:0] arr_addr = (state_reg == ST_IDLE) ? tgt_addr :
    cmd_reg.addr;
  // loader fetches offset by the loader base
  wire logic [13:0] fetch_phys = boot_loader_reg ?
    14'(cpu_fetch_addr_i + FIS_LDR_BASE) : cpu_fetch_addr_i;

  fis_flash_array fis_flash_array_inst (
    .clk_i(clk_i),
    // program data port to latched address
    .we_i(do_prog),
    .erase_i(do_erase),
    .addr_i(arr_addr),
    .wdata_i(cmd_reg.wdata),
    .fetch_addr_i(fetch_phys),
    .rdata_o(flash_rdata),
    .fetch_data_o(cpu_fetch_data_o)
  );

  // data port; read result lands at completion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_data_port_reg <= FIS_RST_DATA;
    end else if (state_reg == ST_DONE && cmd_reg.mode == FIS_MS_READ) begin
      flash_data_port_reg <= flash_rdata;
    end else if (wr && reg_idx == FIS_OFS_DATA) begin
      flash_data_port_reg <= wd;
    end
  end

  // address, mode, divider and limit registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_addr_high_reg <= FIS_RST_ZERO;
      flash_addr_low_reg <= FIS_RST_ZERO;
      flash_mode_select_reg <= FIS_MS_STBY;
      flash_timebase_div_reg <= 6'h00;
      limit_reg <= FIS_RST_LIMIT;
    end else if (wr) begin
      if (reg_idx == FIS_OFS_ADRH) flash_addr_high_reg <= wd;
      if (reg_idx == FIS_OFS_ADRL) flash_addr_low_reg <= wd;
      if (reg_idx == FIS_OFS_MODE) flash_mode_select_reg <= wd[2:0];
      if (reg_idx == FIS_OFS_CLK) flash_timebase_div_reg <= wd[5:0];
      if (reg_idx == FIS_OFS_LIMIT) limit_reg <= {wd[5:0], 8'hFF};
    end
  end

  // control bits; fail set by hardware wins over software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_engine_enable_reg <= 1'b0;
      sw_boot_target_reg <= 1'b0;
      command_fail_flag_reg <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        prog_engine_enable_reg <= wd[FIS_CTRL_EN];
        sw_boot_target_reg <= wd[FIS_CTRL_BS];
      end
      // fail on rejected trigger, clear on success
      if (trigger && !launch) begin
        command_fail_flag_reg <= 1'b1;
      end else if (state_reg == ST_DONE) begin
        command_fail_flag_reg <= 1'b0;
      end else if (ctrl_wr) begin
        command_fail_flag_reg <= wd[FIS_CTRL_FAIL];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg == ST_IDLE) begin
      irq_pend_reg <= 8'h00;
    end else begin
      irq_pend_reg <= irq_pend_reg | irq_req_i;
    end
  end
  // released pending only if flag still active
  assign irq_pend_o = (state_reg == ST_IDLE) ? irq_req_i : 8'h00;

  // freeze the cpu from launch until done
  assign cpu_freeze_o = (state_reg != ST_IDLE);

  // power-on marker; lets the options act once power-on has ended
  logic hw_boot_first;
  logic por_seen_reg;
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      por_seen_reg <= 1'b1;
    end else begin
      por_seen_reg <= 1'b0;
    end
  end
  // hardware options force loader at power-on
  assign hw_boot_first = por_seen_reg & ~por_i & hw_boot_loader_option_i &
    loader_mem_option_i;

  // boot source; ordinary reset must not clear a software boot choice
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      boot_loader_reg <= 1'b0;
      sw_reset_reg <= 1'b0;
    end else if (sw_reset_reg) begin
      sw_reset_reg <= 1'b0;
    end else if (sw_reset_trigger_req) begin
      sw_reset_reg <= 1'b1;
      boot_loader_reg <= wd[FIS_CTRL_BS];
    end else if (ext_reset_done_i && hw_boot_on_ext_reset_i &&
                 hw_boot_loader_option_i && loader_mem_option_i) begin
      boot_loader_reg <= 1'b1;
    end else if (hw_boot_first) begin
      boot_loader_reg <= 1'b1;
    end
  end
  assign sw_reset_o = sw_reset_reg;
  assign boot_loader_o = boot_loader_reg;
  // application starts at zero, loader at its local zero
  assign boot_pc_o = 14'h0000;

  logic [7:0] rd_mux;

  // wishbone answer: one wait cycle, ack one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req & mapped;
      wb_err_o <= bus_req & ~mapped;
      wb_dat_o <= {24'h00_0000, rd_mux};
    end
  end
  assign wb_ack_o = ack_reg;

  // read selection of the byte registers
  always_comb begin
    case (reg_idx)
      FIS_OFS_DATA: rd_mux = flash_data_port_reg;
      FIS_OFS_ADRH: rd_mux = flash_addr_high_reg;
      FIS_OFS_ADRL: rd_mux = flash_addr_low_reg;
      FIS_OFS_MODE: rd_mux = {5'h00, flash_mode_select_reg};
      FIS_OFS_CTRL: rd_mux = {prog_engine_enable_reg, sw_boot_target_reg,
                              1'b0, command_fail_flag_reg, 4'h0};
      FIS_OFS_CLK: rd_mux = {2'h0, flash_timebase_div_reg};
      FIS_OFS_BOOT: rd_mux = {7'h00, boot_loader_reg};
      FIS_OFS_LIMIT: rd_mux = {2'h0, limit_reg[13:8]};
      default: rd_mux = 8'h00;
    endcase
  end

  // checks on the operation flow
  op_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    launch |=> cpu_freeze_o)
    else $error("no freeze after launch");
  freeze_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_DONE |=> !cpu_freeze_o)
    else $error("freeze outlasts operation");
  data_port_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_DONE && cmd_reg.mode == FIS_MS_READ |=>
    flash_data_port_reg == $past(flash_rdata))
    else $error("read result missing from data port");

  // checks on the key gate and refusals
  key_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    key_wr && !prog_engine_enable_reg && !cpu_freeze_o |=> !cpu_freeze_o)
    else $error("key acted while engine disabled");
  bad_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    trigger && !addr_ok |=> !cpu_freeze_o)
    else $error("operation ran beyond data area");
  fail_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    trigger && !launch |=> command_fail_flag_reg)
    else $error("fail flag not set on refusal");
  fail_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_DONE |=> !command_fail_flag_reg)
    else $error("fail flag kept after success");
  key_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
    trigger |-> $past(key_armed_reg))
    else $error("trigger without first key");
  disarm_a: assert property (@(posedge clk_i) disable iff (rst_i)
    key_wr && wd != FIS_KEY1 |=> !key_armed_reg)
    else $error("key detector stayed armed");

  // checks on boot choice and bus answer
  sw_reset_trigger_a: assert property (@(posedge clk_i) disable iff (por_i)
    sw_reset_trigger_req |=> sw_reset_o ##1 !sw_reset_o)
    else $error("software reset pulse wrong");
  hw_boot_a: assert property (@(posedge clk_i) disable iff (por_i)
    hw_boot_first && !sw_reset_reg && !sw_reset_trigger_req |=> boot_loader_o)
    else $error("hardware options did not pick loader");
  ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held");

  // main scenarios
  erase_c: cover property (@(posedge clk_i) do_erase);
  prog_c: cover property (@(posedge clk_i) do_prog);
  read_c: cover property (@(posedge clk_i)
    state_reg == ST_DONE && cmd_reg.mode == FIS_MS_READ);
  held_irq_c: cover property (@(posedge clk_i)
    state_reg == ST_DONE && irq_pend_reg != 8'h00);
  loader_boot_c: cover property (@(posedge clk_i)
    sw_reset_o && boot_loader_o);
endmodule

// File: fis_sequencer_bench.sv
// self-checking bench for the flash sequencer, driven over wishbone
`timescale 1ns/10ps
module fis_sequencer_bench
  import fis_pkg::*;
;
  logic clk_i, rst_i, por_i, ext_reset_done_i;
  logic hw_boot_loader_option_i, loader_mem_option_i, hw_boot_on_ext_reset_i;
  logic [5:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i;
  logic wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o;
  logic [13:0] cpu_fetch_addr_i, boot_pc_o;
  logic [7:0] cpu_fetch_data_o, irq_req_i, irq_pend_o;
  logic cpu_freeze_o, sw_reset_o, boot_loader_o;
  logic [7:0] d;
  logic e;
  int bad_count, comparisons, frz, swr;

  fis_sequencer fis_sequencer_inst (
    .clk_i, .rst_i, .por_i, .hw_boot_loader_option_i, .loader_mem_option_i,
    .hw_boot_on_ext_reset_i, .ext_reset_done_i, .wb_adr_i, .wb_dat_i,
    .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .wb_err_o, .cpu_fetch_addr_i, .cpu_fetch_data_o, .irq_req_i,
    .irq_pend_o, .cpu_freeze_o, .sw_reset_o, .boot_loader_o, .boot_pc_o
  );

  // free-running 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x,
      input string m);
    comparisons++;
    if (s !== x) begin
      bad_count++;
      $display("[FAIL] %0t %s: got %h want %h", $time, m, s, x);
    end
  endtask

  task automatic die(input string m);
    bad_count++;
    $display("[FAIL] %0t %s", $time, m);
    print_verdict();
  endtask

  // one classic cycle; a hung slave ends the run rather than the bench
  task automatic xfer(input logic [3:0] a, input logic w,
      input logic [7:0] wd, output logic [7:0] rd_o, output logic er);
    int n;
    @(posedge clk_i);
    wb_adr_i <= {a, 2'b00};
    wb_we_i <= w;
    wb_dat_i <= {24'h00_0000, wd};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) break;
    end
    if (n == 50) die("no bus answer");
    rd_o = wb_dat_o[7:0];
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    xfer(a, 1'b1, v, d, e);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    xfer(a, 1'b0, 8'h00, d, e);
    chk(d, x, "register read");
  endtask

  // freeze may rise a cycle late, so let it start before polling
  task automatic wait_idle();
    int n;
    repeat (3) @(posedge clk_i);
    for (n = 0; n < 2000; n++) begin
      if (cpu_freeze_o === 1'b0) break;
      @(posedge clk_i);
    end
    if (n == 2000) die("freeze never ended");
  endtask

  function automatic int flen(int dv, int ln);
    return (dv + 1) * (ln + 1) + 1;
  endfunction

  // load mode, address and data, unlock, then time the freeze
  task automatic op(input logic [2:0] m, input logic [13:0] a,
      input logic [7:0] wd, input int len);
    wr(FIS_OFS_MODE, {5'h00, m});
    wr(FIS_OFS_ADRH, {2'b00, a[13:8]});
    wr(FIS_OFS_ADRL, a[7:0]);
    wr(FIS_OFS_DATA, wd);
    frz = 0;
    wr(FIS_OFS_KEY, FIS_KEY1);
    wr(FIS_OFS_KEY, FIS_KEY2);
    wait_idle();
    if (len >= 0) chk(32'(frz), 32'(len), "freeze length");
  endtask

  // freeze length, interrupt masking and reset pulse counting
  always @(posedge clk_i) begin
    if (cpu_freeze_o === 1'b1) begin
      frz++;
      chk(irq_pend_o, 8'h00, "irq while frozen");
    end
    if (sw_reset_o === 1'b1) swr++;
  end

  initial begin
    {rst_i, por_i, ext_reset_done_i, wb_we_i, wb_cyc_i, wb_stb_i} = 6'h30;
    {hw_boot_loader_option_i, loader_mem_option_i} = 2'b00;
    hw_boot_on_ext_reset_i = 1'b0;
    wb_adr_i = 6'h00;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'h1;
    cpu_fetch_addr_i = 14'h0204;
    irq_req_i = 8'h00;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    rd(FIS_OFS_DATA, FIS_RST_DATA);
    rd(FIS_OFS_CTRL, FIS_RST_ZERO);
    chk(boot_loader_o, 1'b0, "boot after por");
    $display("test reset done");
    // erase, read and program, each with its own freeze length
    wr(FIS_OFS_CLK, 8'h00);
    wr(FIS_OFS_CTRL, 8'h80);
    // level requests stay up across every freeze
    irq_req_i <= 8'h81;
    // erase address keeps the low nine bits zero
    op(FIS_MS_ERASE, 14'h0200, 8'h00, flen(0, FIS_T_ERASE));
    op(FIS_MS_READ, 14'h03FF, 8'h00, flen(0, FIS_T_READ));
    rd(FIS_OFS_DATA, 8'hFF);
    chk(irq_pend_o, 8'h81, "irq after freeze");
    op(FIS_MS_PROG, 14'h0204, 8'hA5, flen(0, FIS_T_PROG));
    op(FIS_MS_READ, 14'h0204, 8'h00, flen(0, FIS_T_READ));
    rd(FIS_OFS_DATA, 8'hA5);
    op(FIS_MS_PROG, 14'h0204, 8'h5A, flen(0, FIS_T_PROG));
    wr(FIS_OFS_CLK, 8'h01);
    op(FIS_MS_READ, 14'h0204, 8'h00, flen(1, FIS_T_READ));
    rd(FIS_OFS_DATA, 8'h00);
    rd(FIS_OFS_CTRL, 8'h80);
    chk(cpu_fetch_data_o, 8'h00, "fetch");
    $display("test operations done");
    // key errors, disabled engine, out-of-range and bad mode
    frz = 0;
    wr(FIS_OFS_KEY, FIS_KEY1);
    wr(FIS_OFS_KEY, 8'h00);
    wr(FIS_OFS_KEY, FIS_KEY2);
    wait_idle();
    chk(32'(frz), 32'h0000_0000, "broken key");
    wr(FIS_OFS_CTRL, 8'h00);
    op(FIS_MS_READ, 14'h0204, 8'h33, 0);
    rd(FIS_OFS_DATA, 8'h33);
    wr(FIS_OFS_CTRL, 8'h80);
    op(FIS_MS_READ, FIS_LDR_BASE, 8'h44, 0);
    rd(FIS_OFS_DATA, 8'h44);
    rd(FIS_OFS_CTRL, 8'h90);
    // clear the fail flag so the bad mode must set it again
    wr(FIS_OFS_CTRL, 8'h80);
    rd(FIS_OFS_CTRL, 8'h80);
    op(3'h4, 14'h0204, 8'h00, 0);
    rd(FIS_OFS_CTRL, 8'h90);
    op(FIS_MS_READ, 14'h0204, 8'h00, flen(1, FIS_T_READ));
    rd(FIS_OFS_CTRL, 8'h80);
    xfer(4'hF, 1'b0, 8'h00, d, e);
    chk(e, 1'b1, "unmapped access");
    $display("test refusals done");
    // software and hardware boot choices; seed the loader area first
    wr(FIS_OFS_LIMIT, 8'h3F);
    rd(FIS_OFS_LIMIT, 8'h3F);
    op(FIS_MS_ERASE, FIS_LDR_BASE, 8'h00, flen(1, FIS_T_ERASE));
    op(FIS_MS_PROG, FIS_LDR_BASE + 14'h0010, 8'hC3,
      flen(1, FIS_T_PROG));
    cpu_fetch_addr_i <= 14'h0010;
    swr = 0;
    wr(FIS_OFS_CTRL, 8'hE0);
    repeat (3) @(posedge clk_i);
    chk(boot_loader_o, 1'b1, "sw boot loader");
    chk(cpu_fetch_data_o, 8'hC3, "loader fetch");
    wr(FIS_OFS_CTRL, 8'hA0);
    repeat (3) @(posedge clk_i);
    chk(boot_loader_o, 1'b0, "sw boot app");
    chk(32'(swr), 32'h0000_0002, "reset pulses");
    chk(boot_pc_o, 14'h0000, "app start");
    hw_boot_loader_option_i <= 1'b1;
    loader_mem_option_i <= 1'b1;
    por_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    por_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(boot_loader_o, 1'b1, "hw boot");
    rd(FIS_OFS_BOOT, 8'h01);
    wr(FIS_OFS_CTRL, 8'hA0);
    repeat (3) @(posedge clk_i);
    chk(boot_loader_o, 1'b0, "leave loader");
    hw_boot_on_ext_reset_i <= 1'b1;
    ext_reset_done_i <= 1'b1;
    @(posedge clk_i);
    ext_reset_done_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(boot_loader_o, 1'b1, "ext reset boot");
    $display("test boot done");
    print_verdict();
  end
endmodule
